// >>> design/maf_pkg.sv
// Shared constants and helpers for the multi-channel alignment FIFO and its host controller.
package maf_pkg;
  localparam int NUM_LINKS = 8;
  localparam int FIFO_DEPTH = 10;
  localparam int PTR_W = 4;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int CNT_W = 5;
  localparam int INF_W = 3;

  // Timing, in reference clock cycles (100 MHz, 10 ns period).
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [CNT_W-1:0] READ_LATENCY = 5'h09;
  localparam logic [CNT_W-1:0] SKEW_MAX = 5'h12;
  localparam logic [INF_W-1:0] FRAMES_TO_INFRAME = 3'h4;
  localparam logic [PTR_W-1:0] LAST_ADDR = 4'h9;

  // Device register map.
  localparam logic [ADDR_W-1:0] REG_ALIGN_CTRL = 20'h30020;
  localparam logic [ADDR_W-1:0] REG_AIS_CTRL = 20'h30068;
  localparam logic [ADDR_W-1:0] REG_CHAN_EN = 20'h30070;
  localparam logic [ADDR_W-1:0] REG_ALARM = 20'h30074;
  localparam logic [ADDR_W-1:0] REG_STATUS = 20'h30078;
  localparam int BIT_REALIGN = 6;
  localparam int BIT_AIS = 6;
  localparam int BIT_OOS = 0;
  localparam int BIT_READING = 1;
  localparam logic [NUM_LINKS-1:0] CHAN_EN_RST = 8'hFF;
  localparam logic [DATA_W-1:0] REALIGN_VALUE = 32'h00000040;

  // Host controller register map (AXI4-Lite byte addresses).
  localparam int HA_W = 8;
  localparam logic [HA_W-1:0] H_DEV_ADDR = 8'h00;
  localparam logic [HA_W-1:0] H_DEV_WDATA = 8'h04;
  localparam logic [HA_W-1:0] H_CTRL = 8'h08;
  localparam logic [HA_W-1:0] H_DEV_RDATA = 8'h0C;
  localparam logic [HA_W-1:0] H_STATUS = 8'h10;
  localparam int C_WRITE = 0;
  localparam int C_READ = 1;
  localparam int C_UMI = 2;
  localparam int C_REALIGN = 3;
  localparam int C_AUTO = 4;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_REFUSED = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [DATA_W-1:0] swap32(input logic [DATA_W-1:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
endpackage

// >>> design/maf_reg_if.sv
// Register access port between the host controller and the alignment FIFO device.
`timescale 1ns/1ps
interface maf_reg_if (
  input wire logic clock_i
);
  logic req;
  logic we;
  logic bus_user_master_port;
  logic [maf_pkg::ADDR_W-1:0] addr;
  logic [maf_pkg::DATA_W-1:0] wdata;
  logic ack;
  logic [maf_pkg::DATA_W-1:0] rdata;

  modport dev (input req, input we, input bus_user_master_port, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output bus_user_master_port, output addr, output wdata, input ack,
                input rdata);
endinterface

// >>> design/maf_align_dev.sv
// Multi-channel alignment FIFO: per-link write, synchronized group read, out-of-sync alarm.
`timescale 1ns/1ps
module maf_align_dev (
  input wire logic clock_i, // Local reference clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable; state freezes while low.
  maf_reg_if.dev regs, // Register port from the host.
  input wire logic [maf_pkg::NUM_LINKS*maf_pkg::BYTE_W-1:0] link_data_i, // Framer bytes.
  input wire logic [maf_pkg::NUM_LINKS-1:0] frame_pulse_i, // Framer frame pulses.
  input wire logic [maf_pkg::NUM_LINKS-1:0] framer_in_frame_i, // Framer frame lock.
  output logic [maf_pkg::NUM_LINKS*maf_pkg::BYTE_W-1:0] aligned_data_o, // Aligned bytes.
  output logic aligned_valid_o, // Aligned bytes are valid.
  output logic out_of_sync_o, // Group failed to align.
  output logic [maf_pkg::NUM_LINKS-1:0] out_of_frame_o, // Per-channel alarm.
  output logic ais_force_o // AIS-L forced on the group.
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_COLLECT,
    ST_READ,
    ST_OOS
  } maf_state_t;

  maf_state_t state;
  logic [maf_pkg::BYTE_W-1:0] mem [maf_pkg::NUM_LINKS][maf_pkg::FIFO_DEPTH];
  logic [maf_pkg::PTR_W-1:0] wptr [maf_pkg::NUM_LINKS];
  logic [maf_pkg::PTR_W-1:0] rptr;
  logic [maf_pkg::NUM_LINKS-1:0] seen;
  logic [maf_pkg::NUM_LINKS-1:0] chan_en;
  logic [maf_pkg::NUM_LINKS-1:0] pulses;
  logic [maf_pkg::NUM_LINKS-1:0] in_frame;
  logic [maf_pkg::INF_W-1:0] frame_cnt [maf_pkg::NUM_LINKS];
  logic [maf_pkg::CNT_W-1:0] cnt_first;
  logic [maf_pkg::CNT_W-1:0] cnt_last;
  logic [maf_pkg::CNT_W-1:0] spread;
  logic group_done;
  logic realign;
  logic reg_take;
  logic [maf_pkg::DATA_W-1:0] wval;
  logic [maf_pkg::DATA_W-1:0] rval;

  function automatic logic [maf_pkg::PTR_W-1:0] wrap_inc(input logic [maf_pkg::PTR_W-1:0] p);
    return (p == maf_pkg::LAST_ADDR) ? '0 : p + 4'h1;
  endfunction

  // Disabled links neither arm the group nor hold it back.
  assign pulses = frame_pulse_i & chan_en;
  assign group_done = (((seen | pulses) & chan_en) == chan_en);
  assign spread = cnt_first - cnt_last;

  // Register port: one request taken per handshake, answered one cycle later.
  assign reg_take = regs.req & ~regs.ack;
  assign wval = regs.bus_user_master_port ? maf_pkg::swap32(regs.wdata) : regs.wdata;
  assign realign = reg_take & regs.we & (regs.addr == maf_pkg::REG_ALIGN_CTRL)
                   & wval[maf_pkg::BIT_REALIGN];

  always_comb begin
    rval = '0;
    unique case (regs.addr)
      maf_pkg::REG_AIS_CTRL: rval[maf_pkg::BIT_AIS] = ais_force_o;
      maf_pkg::REG_CHAN_EN: rval[maf_pkg::NUM_LINKS-1:0] = chan_en;
      maf_pkg::REG_ALARM: rval[maf_pkg::NUM_LINKS-1:0] = out_of_frame_o;
      maf_pkg::REG_STATUS: begin
        rval[maf_pkg::BIT_OOS] = out_of_sync_o;
        rval[maf_pkg::BIT_READING] = aligned_valid_o;
      end
      default: rval = '0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      regs.ack <= 1'b0;
      regs.rdata <= '0;
    end else if (ce_i) begin
      regs.ack <= reg_take;
      // A write leaves the last read word standing until the next read is taken.
      if (reg_take && !regs.we) begin
        regs.rdata <= regs.bus_user_master_port ? maf_pkg::swap32(rval) : rval;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      chan_en <= maf_pkg::CHAN_EN_RST;
      ais_force_o <= 1'b0;
    end else if (ce_i && reg_take && regs.we) begin
      if (regs.addr == maf_pkg::REG_CHAN_EN) begin
        chan_en <= wval[maf_pkg::NUM_LINKS-1:0];
      end
      if (regs.addr == maf_pkg::REG_AIS_CTRL) begin
        ais_force_o <= wval[maf_pkg::BIT_AIS];
      end
    end
  end

  // Both FIFO sides run on the reference clock, so the sender must share its source.
  genvar g;
  generate
    for (g = 0; g < maf_pkg::NUM_LINKS; g++) begin : g_link
      always_ff @(posedge clock_i) begin
        if (ce_i) begin
          mem[g][wptr[g]] <= link_data_i[g*maf_pkg::BYTE_W +: maf_pkg::BYTE_W];
        end
      end

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          wptr[g] <= '0;
        end else if (ce_i) begin
          if (frame_pulse_i[g]) begin
            wptr[g] <= '0;
          end else if (seen[g]) begin
            wptr[g] <= wrap_inc(wptr[g]);
          end else begin
            wptr[g] <= '0;
          end
        end
      end

      // The framer's lock is trusted only after enough frames have been counted.
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          frame_cnt[g] <= '0;
          in_frame[g] <= 1'b0;
        end else if (ce_i) begin
          if (!framer_in_frame_i[g]) begin
            frame_cnt[g] <= '0;
            in_frame[g] <= 1'b0;
          end else if (frame_pulse_i[g] && !in_frame[g]) begin
            frame_cnt[g] <= frame_cnt[g] + 3'h1;
            in_frame[g] <= (frame_cnt[g] + 3'h1 == maf_pkg::FRAMES_TO_INFRAME);
          end
        end
      end

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          aligned_data_o[g*maf_pkg::BYTE_W +: maf_pkg::BYTE_W] <= '0;
        end else if (ce_i) begin
          aligned_data_o[g*maf_pkg::BYTE_W +: maf_pkg::BYTE_W] <=
            ais_force_o ? 8'hFF : mem[g][rptr];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      out_of_frame_o <= {maf_pkg::NUM_LINKS{1'b1}};
    end else if (ce_i) begin
      out_of_frame_o <= ~in_frame;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seen <= '0;
    end else if (ce_i) begin
      if (realign) begin
        seen <= '0;
      end else if (state == ST_ARMED || state == ST_COLLECT) begin
        seen <= seen | frame_pulse_i;
      end
    end
  end

  // Alignment sequencer; a realign request restarts it from any state.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt_first <= '0;
      cnt_last <= '0;
    end else if (ce_i) begin
      if (realign) begin
        state <= ST_ARMED;
      end else begin
        unique case (state)
          ST_IDLE, ST_READ, ST_OOS: state <= state;
          ST_ARMED: begin
            if (|pulses) begin
              state <= ST_COLLECT;
              cnt_first <= 5'h01;
              cnt_last <= 5'h01;
            end
          end
          ST_COLLECT: begin
            cnt_first <= cnt_first + 5'h01;
            cnt_last <= (|pulses) ? 5'h01 : cnt_last + 5'h01;
            if (!group_done && cnt_first == maf_pkg::SKEW_MAX) begin
              state <= ST_OOS;
            end else if (group_done && !(|pulses) && cnt_last == maf_pkg::READ_LATENCY) begin
              state <= ST_READ;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rptr <= '0;
    end else if (ce_i) begin
      if (state == ST_READ) begin
        rptr <= wrap_inc(rptr);
      end else if (spread == '0 || spread > maf_pkg::CNT_W'(maf_pkg::FIFO_DEPTH)) begin
        rptr <= '0;
      end else begin
        // Start behind the last link but within one lap of the first, so no lane is overrun.
        rptr <= maf_pkg::PTR_W'(spread - 5'h01);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aligned_valid_o <= 1'b0;
      out_of_sync_o <= 1'b0;
    end else if (ce_i) begin
      aligned_valid_o <= (state == ST_READ) && !realign;
      out_of_sync_o <= (state == ST_OOS) && !realign;
    end
  end
endmodule

// >>> design/maf_align_host.sv
// Host controller: AXI4-Lite registers, device port accesses and the realignment sequence.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module maf_align_host (
  input wire logic clock_i, // Reference clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable; state freezes while low.
  input wire logic [maf_pkg::HA_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [maf_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [maf_pkg::HA_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [maf_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  maf_reg_if.host regs, // Register port to the device.
  output logic busy_o // A commanded device access or a realignment write is running.
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_ACC,
    H_CHK,
    H_W1,
    H_W2,
    H_POLL
  } maf_hstate_t;

  maf_hstate_t state;
  logic aw_got;
  logic w_got;
  logic [maf_pkg::HA_W-1:0] awaddr_q;
  logic [maf_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic commit;
  logic [maf_pkg::ADDR_W-1:0] dev_addr;
  logic [maf_pkg::DATA_W-1:0] dev_wdata;
  logic [maf_pkg::DATA_W-1:0] dev_rdata;
  logic [4:0] ctrl;
  logic done_flag;
  logic refused_flag;
  logic go_wr;
  logic go_rd;
  logic go_align;
  logic clr_done;
  logic clr_refused;
  logic ctrl_wr;
  logic umi_now;
  logic prev_oof;
  logic acc_done;
  logic [maf_pkg::DATA_W-1:0] ack_val;
  logic [maf_pkg::DATA_W-1:0] rmux;

  function automatic logic [maf_pkg::DATA_W-1:0] merge(input logic [maf_pkg::DATA_W-1:0] old,
      input logic [maf_pkg::DATA_W-1:0] nw, input logic [3:0] strb);
    logic [maf_pkg::DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign commit = aw_got & w_got & ~s_axi_bvalid;
  assign go_wr = commit && awaddr_q == maf_pkg::H_CTRL && wstrb_q[0] && wdata_q[maf_pkg::C_WRITE];
  assign go_rd = commit && awaddr_q == maf_pkg::H_CTRL && wstrb_q[0] && wdata_q[maf_pkg::C_READ];
  assign go_align = commit && awaddr_q == maf_pkg::H_CTRL && wstrb_q[0]
                    && wdata_q[maf_pkg::C_REALIGN];
  assign clr_done = commit && awaddr_q == maf_pkg::H_STATUS && wstrb_q[0]
                    && wdata_q[maf_pkg::S_DONE];
  assign clr_refused = commit && awaddr_q == maf_pkg::H_STATUS && wstrb_q[0]
                       && wdata_q[maf_pkg::S_REFUSED];
  assign acc_done = regs.req & regs.ack;
  assign ack_val = regs.bus_user_master_port ? maf_pkg::swap32(regs.rdata) : regs.rdata;
  assign ctrl_wr = commit && awaddr_q == maf_pkg::H_CTRL && wstrb_q[0];
  // A go and a path change in one write must already use the new path.
  assign umi_now = ctrl_wr ? wdata_q[maf_pkg::C_UMI] : ctrl[maf_pkg::C_UMI];

  // AXI write channels: address and data are taken in either order, response follows both.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= maf_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got && !commit) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got && !commit) begin
        s_axi_wready <= 1'b1;
      end
      if (commit) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > maf_pkg::H_STATUS) ? maf_pkg::RESP_SLVERR : maf_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dev_addr <= '0;
      dev_wdata <= '0;
      ctrl <= '0;
    end else if (ce_i && commit) begin
      unique case (awaddr_q)
        maf_pkg::H_DEV_ADDR: dev_addr <= maf_pkg::ADDR_W'(merge(32'(dev_addr), wdata_q, wstrb_q));
        maf_pkg::H_DEV_WDATA: dev_wdata <= merge(dev_wdata, wdata_q, wstrb_q);
        maf_pkg::H_CTRL: if (wstrb_q[0]) begin
          ctrl <= '0;
          ctrl[maf_pkg::C_UMI] <= wdata_q[maf_pkg::C_UMI];
          ctrl[maf_pkg::C_AUTO] <= wdata_q[maf_pkg::C_AUTO];
        end
        default: ctrl <= ctrl;
      endcase
    end
  end

  always_comb begin
    rmux = '0;
    unique case (s_axi_araddr)
      maf_pkg::H_DEV_ADDR: rmux = 32'(dev_addr);
      maf_pkg::H_DEV_WDATA: rmux = dev_wdata;
      maf_pkg::H_CTRL: rmux = 32'(ctrl);
      maf_pkg::H_DEV_RDATA: rmux = dev_rdata;
      maf_pkg::H_STATUS: rmux = {29'h0, refused_flag, done_flag, busy_o};
      default: rmux = '0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= maf_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= (s_axi_araddr > maf_pkg::H_STATUS) ? maf_pkg::RESP_SLVERR
                                                         : maf_pkg::RESP_OKAY;
      end else begin
        if (s_axi_rvalid && s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
        if (!s_axi_rvalid) begin
          s_axi_arready <= 1'b1;
        end
      end
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
      refused_flag <= 1'b0;
    end else if (ce_i) begin
      if (state == H_W2 && acc_done) begin
        done_flag <= 1'b1;
      end else if (clr_done) begin
        done_flag <= 1'b0;
      end
      if (state == H_CHK && acc_done && |ack_val[maf_pkg::NUM_LINKS-1:0]) begin
        refused_flag <= 1'b1;
      end else if (clr_refused) begin
        refused_flag <= 1'b0;
      end
    end
  end

  // Each state that touches the device raises req, then drops it on the cycle ack is seen, unless H_CHK, H_POLL or H_W1 raises it again for the next write.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= H_IDLE;
      busy_o <= 1'b0;
      prev_oof <= 1'b0;
      dev_rdata <= '0;
      regs.req <= 1'b0;
      regs.we <= 1'b0;
      regs.bus_user_master_port <= 1'b0;
      regs.addr <= '0;
      regs.wdata <= '0;
    end else if (ce_i) begin
      if (acc_done) begin
        regs.req <= 1'b0;
      end
      unique case (state)
        H_IDLE: begin
          regs.bus_user_master_port <= umi_now;
          if (go_wr || go_rd) begin
            state <= H_ACC;
            busy_o <= 1'b1;
            regs.req <= 1'b1;
            regs.we <= go_wr;
            regs.addr <= dev_addr;
            regs.wdata <= umi_now ? maf_pkg::swap32(dev_wdata)
                                  : dev_wdata;
          end else if (go_align || ctrl[maf_pkg::C_AUTO]) begin
            state <= go_align ? H_CHK : H_POLL;
            busy_o <= go_align;
            regs.req <= 1'b1;
            regs.we <= 1'b0;
            regs.addr <= maf_pkg::REG_ALARM;
          end
        end
        H_ACC: if (acc_done) begin
          dev_rdata <= ack_val;
          state <= H_IDLE;
          busy_o <= 1'b0;
        end
        H_CHK, H_POLL: if (acc_done) begin
          prev_oof <= |ack_val[maf_pkg::NUM_LINKS-1:0];
          if (!(|ack_val[maf_pkg::NUM_LINKS-1:0]) && (state == H_CHK || prev_oof)) begin
            state <= H_W1;
            busy_o <= 1'b1;
            regs.req <= 1'b1;
            regs.we <= 1'b1;
            regs.addr <= maf_pkg::REG_ALIGN_CTRL;
            regs.wdata <= regs.bus_user_master_port ? maf_pkg::swap32(maf_pkg::REALIGN_VALUE)
                                   : maf_pkg::REALIGN_VALUE;
          end else begin
            state <= H_IDLE;
            busy_o <= 1'b0;
          end
        end
        H_W1: if (acc_done) begin
          state <= H_W2;
          regs.req <= 1'b1;
          regs.addr <= maf_pkg::REG_AIS_CTRL;
        end
        H_W2: if (acc_done) begin
          state <= H_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> verif/maf_checker.sv
// Checker for the register port and the alignment outputs of the device.
`timescale 1ns/1ps
module maf_checker (
  input wire logic clock_i, // Reference clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic req, // Port request.
  input wire logic we, // Port write.
  input wire logic ack, // Port answer.
  input wire logic [maf_pkg::DATA_W-1:0] rdata, // Port read data.
  input wire logic [maf_pkg::NUM_LINKS-1:0] frame_pulse_i, // Frame pulses.
  input wire logic aligned_valid_o, // Group reading.
  input wire logic out_of_sync_o, // Group alarm.
  input wire logic [maf_pkg::NUM_LINKS-1:0] out_of_frame_o // Channel alarms.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    req && !ack;
  endsequence
  a_ack_next: assert property (s_taken |=> ack) else $error("ack late");
  a_ack_single: assert property (ack |=> !ack) else $error("ack too long");
  a_req_hold: assert property (s_taken |=> req) else $error("req dropped early");
  a_ack_cause: assert property (ack |-> $past(req)) else $error("ack without req");
  a_rdata_hold: assert property (!(req && !ack && !we) |=> $stable(rdata))
    else $error("rdata moved");
  // The read starts nine cycles after the last pulse and valid follows one edge later.
  a_read_delay: assert property ($rose(aligned_valid_o) |-> $past(|frame_pulse_i, 11))
    else $error("read start misplaced");
  a_sync_excl: assert property (out_of_sync_o |-> !aligned_valid_o)
    else $error("reading while out of sync");
  a_oof_reset: assert property ($fell(rst_i) |-> out_of_frame_o == 8'hFF)
    else $error("alarm not set after reset");
endmodule

// >>> verif/multi_channel_alignment_fifo_test.sv
// Testbench: host controller and alignment FIFO device joined over the register port.
`timescale 1ns/1ps
module multi_channel_alignment_fifo_test;
  logic clock_i = 0;
  logic rst_i = 1;
  logic [7:0] awa = 0;
  logic awv = 0;
  logic [31:0] wd = 0;
  logic wv = 0;
  logic bre = 0;
  logic [7:0] ara = 0;
  logic arv = 0;
  logic rre = 0;
  logic awr, wr_r, bv, arr, rv, busy, av, oos, ais;
  logic [1:0] br, rr;
  logic [31:0] rd_d, v;
  logic [63:0] ld = 0;
  logic [63:0] ad;
  logic [7:0] fp = 0;
  logic [7:0] inf = 0;
  logic [7:0] out_of_frame, t = 0, b;
  logic [1:0] r;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int sk = 0;
  int n;
  always #5 clock_i = ~clock_i;
  maf_reg_if bus (.clock_i(clock_i));
  maf_align_host maf_align_host_i (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .regs(bus), .busy_o(busy));
  maf_align_dev maf_align_dev_i (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .regs(bus),
    .link_data_i(ld), .frame_pulse_i(fp), .framer_in_frame_i(inf), .aligned_data_o(ad),
    .aligned_valid_o(av), .out_of_sync_o(oos), .out_of_frame_o(out_of_frame), .ais_force_o(ais));
  maf_checker maf_checker_i (.clock_i(clock_i), .rst_i(rst_i), .req(bus.req), .we(bus.we),
    .ack(bus.ack), .rdata(bus.rdata), .frame_pulse_i(fp), .aligned_valid_o(av),
    .out_of_sync_o(oos), .out_of_frame_o(out_of_frame));
  // Link i carries the same count as link 0, delayed by i*sk cycles.
  always @(posedge clock_i) begin
    t <= t + 8'h01;
    for (int i = 0; i < 8; i++) ld[8*i +: 8] <= t - 8'(i * sk);
  end
  // The whole run takes a few hundred cycles; this ceiling cuts a hang.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, pa, pw;
    ta = 0;
    tw = 0;
    @(posedge clock_i);
    awa <= a;
    awv <= 1;
    wd <= d;
    wv <= 1;
    while (!(ta && tw)) begin
      @(negedge clock_i);
      pa = awr && !ta;
      pw = wr_r && !tw;
      @(posedge clock_i);
      if (pa) awv <= 0;
      if (pw) wv <= 0;
      ta = ta || pa;
      tw = tw || pw;
    end
    bre <= 1;
    do @(negedge clock_i); while (bv !== 1'b1);
    chk("bresp", br, maf_pkg::RESP_OKAY);
    @(posedge clock_i);
    bre <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clock_i);
    ara <= a;
    arv <= 1;
    do @(negedge clock_i); while (arr !== 1'b1);
    @(posedge clock_i);
    arv <= 0;
    rre <= 1;
    do @(negedge clock_i); while (rv !== 1'b1);
    d = rd_d;
    rs = rr;
    @(posedge clock_i);
    rre <= 0;
  endtask
  task automatic cmd(input logic [31:0] c);
    wr(maf_pkg::H_CTRL, c);
    do @(negedge clock_i); while (busy !== 1'b0);
  endtask
  task automatic dev(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
    wr(maf_pkg::H_DEV_ADDR, a);
    wr(maf_pkg::H_DEV_WDATA, d);
    cmd(c);
  endtask
  task automatic pulses(input int s, input logic [7:0] m);
    @(posedge clock_i);
    for (int c = 0; c <= 7 * s; c++) begin
      for (int i = 0; i < 8; i++) fp[i] <= m[i] && (i * s == c);
      @(posedge clock_i);
    end
    fp <= 0;
  endtask
  task automatic align(input int s, input logic [7:0] m);
    cmd(32'h08);
    rd(maf_pkg::H_STATUS, v, r);
    chk("realign done", v, 32'h02);
    chk("ais forced", ais, 1);
    wr(maf_pkg::H_STATUS, 32'h06);
    dev(maf_pkg::REG_AIS_CTRL, 0, 32'h01);
    sk = s;
    repeat (12) @(posedge clock_i);
    pulses(s, m);
  endtask
  task automatic lat();
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (av !== 1'b1 && n < 40);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 0;
    @(negedge clock_i);
    chk("oof after reset", out_of_frame, 8'hFF);
    rd(maf_pkg::H_STATUS, v, r);
    chk("status", v, 0);
    rd(8'h14, v, r);
    chk("unmapped resp", r, maf_pkg::RESP_SLVERR);
    inf <= 8'hFF;
    repeat (3) begin
      pulses(0, 8'hFF);
      repeat (12) @(posedge clock_i);
    end
    chk("oof three frames", out_of_frame, 8'hFF);
    pulses(0, 8'hFF);
    repeat (2) @(negedge clock_i);
    chk("oof in frame", out_of_frame, 8'h00);
    dev(maf_pkg::REG_AIS_CTRL, 32'h40, 32'h05);
    chk("ais by swapped write", ais, 1);
    dev(maf_pkg::REG_AIS_CTRL, 0, 32'h02);
    rd(maf_pkg::H_DEV_RDATA, v, r);
    chk("ais readback", v, 32'h40);
    align(0, 8'hFF);
    lat();
    chk("read delay", n, 10);
    align(1, 8'hFF);
    lat();
    chk("skew delay", n, 10);
    repeat (4) begin
      b = ad[7:0];
      @(posedge clock_i);
      #1;
      chk("step", ad[7:0], b + 8'h01);
      for (int i = 1; i < 8; i++) chk("lane", ad[8*i +: 8], ad[7:0]);
    end
    align(0, 8'h7F);
    repeat (19) @(posedge clock_i);
    #1;
    chk("out of sync", oos, 1);
    chk("no read", av, 0);
    inf <= 8'hFE;
    repeat (3) @(posedge clock_i);
    cmd(32'h08);
    rd(maf_pkg::H_STATUS, v, r);
    chk("realign refused", v, 32'h04);
    wr(maf_pkg::H_STATUS, 32'h06);
    wr(maf_pkg::H_CTRL, 32'h10);
    inf <= 8'hFF;
    repeat (4) pulses(0, 8'h01);
    repeat (20) @(posedge clock_i);
    rd(maf_pkg::H_STATUS, v, r);
    chk("auto realign", v, 32'h02);
    chk("auto ais", ais, 1);
    summarize();
  end
endmodule
